// *** rtl/afc_map.vh ***
/*
 * Named constants for the host-side controller of a strobe-driven 9-bit
 * asynchronous FIFO device. Assumes a 25 MHz system clock and a device of the
 * 50 ns speed grade; other grades only change the figures below.
 */
`ifndef AFC_MAP_VH
`define AFC_MAP_VH

`define AFC_DW 9
`define AFC_FIFO_DEPTH 8
`define AFC_FIFO_AW 3
`define AFC_FIFO_CW 4
`define AFC_CNT_W 4

`define AFC_CLK_NS 40
`define AFC_PULSE_NS 50
`define AFC_RECOV_NS 15
`define AFC_ACCESS_NS 50
`define AFC_FLAG_NS 45

`define AFC_CEIL_CYC(ns) (((ns) + `AFC_CLK_NS - 1) / `AFC_CLK_NS)

`endif

// *** rtl/afc_fifo.v ***
/*
 * Small synchronous FIFO with a registered head word, used to buffer words on
 * their way to the device. Assumes one clock and a synchronous active-high
 * reset; both sides use valid and ready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.vh"

module afc_fifo #(
   parameter WIDTH = `AFC_DW,
   parameter DEPTH = `AFC_FIFO_DEPTH,
   parameter AW = `AFC_FIFO_AW,
   parameter CW = `AFC_FIFO_CW
) (
   // Clock and reset.
   input wire clk_i,
   input wire reset_i,
   // Filling side.
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output reg in_ready_o,
   // Draining side.
   output reg out_valid_o,
   output reg [WIDTH-1:0] out_data_o,
   input wire out_ready_i
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [CW-1:0] count;
   reg [CW-1:0] next_count;
   wire push;
   wire pop;
   wire load;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   // The head register refills from storage whenever it is empty or drained.
   assign load = (count != {CW{1'b0}}) && (!out_valid_o || pop);

   always @* begin
      next_count = count;
      if (push && !load) begin
         next_count = count + {{(CW-1){1'b0}}, 1'b1};
      end else if (load && !push) begin
         next_count = count - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {CW{1'b0}};
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
         out_data_o <= {WIDTH{1'b0}};
      end else begin
         count <= next_count;
         in_ready_o <= (next_count < DEPTH);
         if (push) begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (load) begin
            out_data_o <= mem[rd_ptr];
            out_valid_o <= 1'b1;
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end else if (pop) begin
            out_valid_o <= 1'b0;
         end
      end
   end

endmodule // afc_fifo

`default_nettype wire

// *** rtl/afc_ctrl.v ***
/*
 * Host controller for a strobe-driven 9-bit asynchronous FIFO device wired in
 * single-device mode. It resets the device, writes buffered words, reads words
 * back and issues retransmit on request. Assumes device pins are synchronous
 * to clk_i and that the device is the only one on its strobes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.vh"

module afc_ctrl (
   // Clock and reset.
   input wire clk_i,
   input wire reset_i,
   // Write stream from the user.
   input wire wr_valid_i,
   input wire [`AFC_DW-1:0] wr_data_i,
   output wire wr_ready_o,
   // Read stream to the user.
   output reg rd_valid_o,
   output reg [`AFC_DW-1:0] rd_data_o,
   input wire rd_ready_i,
   // Retransmit request and status.
   input wire rewind_req_i,
   output reg ready_o,
   // Device pins.
   output reg reset_n_in_o,
   output reg write_n_o,
   output reg read_n_o,
   output reg first_load_rewind_n_o,
   output reg chain_in_n_o,
   output reg [`AFC_DW-1:0] write_data_o,
   input wire [`AFC_DW-1:0] read_data_i,
   input wire full_flag_n_i,
   input wire empty_flag_n_i
);

   // Cycle counts are worked out as integers and cut to the counter width on purpose.
   localparam integer PULSE_INT = `AFC_CEIL_CYC(`AFC_PULSE_NS);
   localparam integer RECOV_INT = `AFC_CEIL_CYC(`AFC_RECOV_NS);
   localparam integer FLAG_INT = `AFC_CEIL_CYC(`AFC_FLAG_NS);
   localparam integer ACCESS_INT = `AFC_CEIL_CYC(`AFC_ACCESS_NS);
   localparam [3:0] PULSE_CYC = PULSE_INT[3:0];
   localparam [3:0] RECOV_CYC = RECOV_INT[3:0];
   localparam [3:0] FLAG_CYC = FLAG_INT[3:0];
   localparam [3:0] ACCESS_CYC = ACCESS_INT[3:0];
   // A strobe stays low for the longer of pulse width and access time.
   localparam [3:0] LOW_CYC = (ACCESS_CYC > PULSE_CYC) ? ACCESS_CYC : PULSE_CYC;
   // Flags are trusted only after both recovery and flag delay have passed.
   localparam [3:0] SETTLE_CYC = (FLAG_CYC > RECOV_CYC) ? FLAG_CYC : RECOV_CYC;

   localparam [6:0] ST_RESET = 7'h01;
   localparam [6:0] ST_RSREC = 7'h02;
   localparam [6:0] ST_IDLE = 7'h04;
   localparam [6:0] ST_WLOW = 7'h08;
   localparam [6:0] ST_RLOW = 7'h10;
   localparam [6:0] ST_RTLOW = 7'h20;
   localparam [6:0] ST_SETTLE = 7'h40;

   reg [6:0] state;
   reg [`AFC_CNT_W-1:0] cnt;
   reg rewind_pend;
   wire buf_valid;
   wire [`AFC_DW-1:0] buf_data;
   wire buf_take;
   wire go_rewind;
   wire go_read;
   wire go_write;

   // Counts load as N-1 so that a phase lasts exactly N cycles.
   function [`AFC_CNT_W-1:0] phase_len;
      input [3:0] cycles;
      begin
         phase_len = cycles - 4'h1;
      end
   endfunction

   afc_fifo #(
      .WIDTH(`AFC_DW),
      .DEPTH(`AFC_FIFO_DEPTH),
      .AW(`AFC_FIFO_AW),
      .CW(`AFC_FIFO_CW)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(wr_valid_i),
      .in_data_i(wr_data_i),
      .in_ready_o(wr_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_take)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Scheduling: retransmit first, then a read into a free slot, then a write.

   assign go_rewind = (state == ST_IDLE) && rewind_pend;
   // A read is only started with the empty flag released.
   assign go_read = (state == ST_IDLE) && !rewind_pend && empty_flag_n_i && !rd_valid_o;
   // A write is only started with the full flag released.
   assign go_write = (state == ST_IDLE) && !rewind_pend && !go_read && full_flag_n_i && buf_valid;
   assign buf_take = go_write;

   ////////////////////////////////////////////////////////////////////////////
   // Strobe sequencer.

   always @(posedge clk_i) begin
      if (reset_i) begin
         state <= ST_RESET;
         cnt <= phase_len(PULSE_CYC);
         reset_n_in_o <= 1'b0;
         write_n_o <= 1'b1;
         read_n_o <= 1'b1;
         first_load_rewind_n_o <= 1'b1;
         chain_in_n_o <= 1'b0;
         write_data_o <= {`AFC_DW{1'b0}};
         rd_valid_o <= 1'b0;
         rd_data_o <= {`AFC_DW{1'b0}};
         rewind_pend <= 1'b0;
         ready_o <= 1'b0;
      end else begin
         // Tied low for single-device mode so the shared pin means retransmit.
         chain_in_n_o <= 1'b0;
         // A request arriving as the previous one is taken is kept pending.
         if (rewind_req_i) begin
            rewind_pend <= 1'b1;
         end else if (go_rewind) begin
            rewind_pend <= 1'b0;
         end
         if (rd_valid_o && rd_ready_i) begin
            rd_valid_o <= 1'b0;
         end
         case (state)
            ST_RESET: begin
               // Device reset is issued before any write, strobes held high.
               reset_n_in_o <= 1'b0;
               write_n_o <= 1'b1;
               read_n_o <= 1'b1;
               if (cnt == {`AFC_CNT_W{1'b0}}) begin
                  reset_n_in_o <= 1'b1;
                  cnt <= phase_len(SETTLE_CYC);
                  state <= ST_RSREC;
               end else begin
                  cnt <= cnt - {{(`AFC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_RSREC: begin
               // Strobes stay unchanged through reset recovery.
               if (cnt == {`AFC_CNT_W{1'b0}}) begin
                  state <= ST_IDLE;
                  ready_o <= 1'b1;
               end else begin
                  cnt <= cnt - {{(`AFC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_IDLE: begin
               cnt <= phase_len(LOW_CYC);
               if (go_rewind) begin
                  // Strobes are high here and stay so until the cycle ends.
                  first_load_rewind_n_o <= 1'b0;
                  state <= ST_RTLOW;
                  ready_o <= 1'b0;
               end else if (go_read) begin
                  read_n_o <= 1'b0;
                  state <= ST_RLOW;
                  ready_o <= 1'b0;
               end else if (go_write) begin
                  // Data is set up with the falling strobe and held past its rise.
                  write_data_o <= buf_data;
                  write_n_o <= 1'b0;
                  state <= ST_WLOW;
                  ready_o <= 1'b0;
               end
            end
            ST_WLOW: begin
               if (cnt == {`AFC_CNT_W{1'b0}}) begin
                  write_n_o <= 1'b1;
                  cnt <= phase_len(SETTLE_CYC);
                  state <= ST_SETTLE;
               end else begin
                  cnt <= cnt - {{(`AFC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_RLOW: begin
               if (cnt == {`AFC_CNT_W{1'b0}}) begin
                  // Data is only driven while the read strobe is low.
                  rd_data_o <= read_data_i;
                  rd_valid_o <= 1'b1;
                  read_n_o <= 1'b1;
                  cnt <= phase_len(SETTLE_CYC);
                  state <= ST_SETTLE;
               end else begin
                  cnt <= cnt - {{(`AFC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_RTLOW: begin
               if (cnt == {`AFC_CNT_W{1'b0}}) begin
                  first_load_rewind_n_o <= 1'b1;
                  cnt <= phase_len(SETTLE_CYC);
                  state <= ST_SETTLE;
               end else begin
                  cnt <= cnt - {{(`AFC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            ST_SETTLE: begin
               // Flags are not looked at until recovery and flag delay expire,
               // which also covers flag toggling inside retransmit.
               if (cnt == {`AFC_CNT_W{1'b0}}) begin
                  state <= ST_IDLE;
                  ready_o <= 1'b1;
               end else begin
                  cnt <= cnt - {{(`AFC_CNT_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               state <= ST_RESET;
               cnt <= phase_len(PULSE_CYC);
               reset_n_in_o <= 1'b0;
               write_n_o <= 1'b1;
               read_n_o <= 1'b1;
               first_load_rewind_n_o <= 1'b1;
               ready_o <= 1'b0;
            end
         endcase
      end
   end

endmodule // afc_ctrl

`default_nettype wire

// *** bench/afc_monitor.sv ***
/* Checker on the device pins of afc_ctrl.
   Assumes afc_map.vh is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.vh"
module afc_monitor (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // Controller pins.
   input wire logic rd_valid_o,
   input wire logic ready_o,
   input wire logic reset_n_in_o,
   input wire logic write_n_o,
   input wire logic read_n_o,
   input wire logic first_load_rewind_n_o,
   input wire logic [`AFC_DW-1:0] write_data_o,
   // Device flags.
   input wire logic full_flag_n_i,
   input wire logic empty_flag_n_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   property p_rst_quiet; !reset_n_in_o |-> write_n_o && read_n_o && first_load_rewind_n_o; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("strobe in reset");
   property p_rst_rec; $rose(reset_n_in_o) |-> (write_n_o && read_n_o)[*2]; endproperty
   a_rst_rec: assert property (p_rst_rec) else $error("strobe in recovery");
   property p_wr_gate; $fell(write_n_o) |-> $past(full_flag_n_i); endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("write while full");
   property p_wr_pulse; $fell(write_n_o) |=> (!write_n_o && $stable(write_data_o)) ##1 write_n_o; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse");
   property p_rd_gate; $fell(read_n_o) |-> $past(empty_flag_n_i) && !$past(rd_valid_o); endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("read while empty");
   property p_rd_pulse; $fell(read_n_o) |=> !read_n_o ##1 (read_n_o && rd_valid_o); endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse");
   property p_rew_quiet; !first_load_rewind_n_o |-> write_n_o && read_n_o; endproperty
   a_rew_quiet: assert property (p_rew_quiet) else $error("strobe in rewind");
   property p_idle_quiet; ready_o |-> write_n_o && read_n_o && first_load_rewind_n_o; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("strobe while idle");
   property p_rew_pulse;
      $fell(first_load_rewind_n_o) |=> !first_load_rewind_n_o ##1 (first_load_rewind_n_o && write_n_o && read_n_o)[*2];
   endproperty
   a_rew_pulse: assert property (p_rew_pulse) else $error("rewind pulse");
   c_write: cover property ($fell(write_n_o));
   c_read: cover property ($fell(read_n_o));
   c_rewind: cover property ($fell(first_load_rewind_n_o));
   c_full: cover property (!full_flag_n_i);
endmodule // afc_monitor
bind afc_ctrl afc_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i), .rd_valid_o(rd_valid_o), .ready_o(ready_o),
   .reset_n_in_o(reset_n_in_o), .write_n_o(write_n_o), .read_n_o(read_n_o),
   .first_load_rewind_n_o(first_load_rewind_n_o), .write_data_o(write_data_o),
   .full_flag_n_i(full_flag_n_i), .empty_flag_n_i(empty_flag_n_i));
`default_nettype wire

// *** bench/afc_dev_model.sv ***
/* Behavioural model of the strobe-driven nine-bit FIFO device.
   Assumes the host keeps strobe widths and flag settle times. */
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.vh"
module afc_dev_model #(
   parameter int DEPTH = 512
) (
   // Controls.
   input wire logic reset_n_in_i,
   input wire logic write_n_i,
   input wire logic read_n_i,
   input wire logic first_load_rewind_n_i,
   input wire logic chain_in_n_i,
   // Data and flags.
   input wire logic [`AFC_DW-1:0] write_data_i,
   output wire logic [`AFC_DW-1:0] read_data_o,
   output wire logic full_flag_n_o,
   output wire logic empty_flag_n_o
);
   localparam int PW = $clog2(DEPTH);
   logic [`AFC_DW-1:0] mem [DEPTH];
   logic [`AFC_DW-1:0] q = '0;
   logic [PW:0] wp, rp;
   logic wr_ok = 1'b0;
   logic rd_ok = 1'b0;
   wire [PW:0] cnt = wp - rp;
   assign #(`AFC_FLAG_NS) full_flag_n_o = (cnt != DEPTH);
   assign #(`AFC_FLAG_NS) empty_flag_n_o = (cnt != 0);
   // Floating pins show the inverse of the held word; until the access time passes, a low strobe still shows the stale word.
   assign read_data_o = read_n_i ? ~q : q;
   always @(negedge reset_n_in_i) begin
      wp = '0;
      rp = '0;
   end
   always @(negedge write_n_i) wr_ok = reset_n_in_i && full_flag_n_o;
   always @(posedge write_n_i) begin
      if (wr_ok && reset_n_in_i) begin
         mem[wp[PW-1:0]] = write_data_i;
         wp = wp + 1'b1;
      end
      wr_ok = 1'b0;
   end
   always @(negedge read_n_i) begin
      rd_ok = reset_n_in_i && empty_flag_n_o;
      if (rd_ok) #(`AFC_ACCESS_NS) q = mem[rp[PW-1:0]];
   end
   always @(posedge read_n_i) begin
      if (rd_ok && reset_n_in_i) rp = rp + 1'b1;
      rd_ok = 1'b0;
   end
   // Chain mode is never entered here, so no hand-over pulse at the last location is modelled.
   always @(negedge first_load_rewind_n_i) begin
      if (reset_n_in_i && !chain_in_n_i) rp = '0;
   end
endmodule // afc_dev_model
`default_nettype wire

// *** bench/tb_top.sv ***
/* Self-checking bench: afc_ctrl driving the device model.
   Assumes afc_map.vh is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "afc_map.vh"
module tb_top;
   logic clk_i, reset_i, wr_valid_i, rd_ready_i, rewind_req_i, hold, ok;
   logic [`AFC_DW-1:0] wr_data_i;
   wire [`AFC_DW-1:0] rd_data_o, wdat, rdat;
   wire wr_ready_o, rd_valid_o, rdy, rst_n, w_n, r_n, rew_n, chain_n, full_n, empty_n;
   integer seed = 32'hbbe66aeb;
   int n_mismatch = 0;
   int check_count = 0;
   logic [`AFC_DW-1:0] exp_q[$];
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   afc_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
      .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i),
      .rewind_req_i(rewind_req_i), .ready_o(rdy), .reset_n_in_o(rst_n), .write_n_o(w_n), .read_n_o(r_n),
      .first_load_rewind_n_o(rew_n), .chain_in_n_o(chain_n), .write_data_o(wdat), .read_data_i(rdat),
      .full_flag_n_i(full_n), .empty_flag_n_i(empty_n));
   afc_dev_model u_dev (.reset_n_in_i(rst_n), .write_n_i(w_n), .read_n_i(r_n), .first_load_rewind_n_i(rew_n),
      .chain_in_n_i(chain_n), .write_data_i(wdat), .read_data_o(rdat), .full_flag_n_o(full_n),
      .empty_flag_n_o(empty_n));
   function automatic logic [`AFC_DW-1:0] word(input int i);
      logic [`AFC_DW-1:0] c [4] = '{9'h1ff, 9'h000, 9'h155, 9'h0aa};
      logic [31:0] r;
      r = $random(seed);
      return (i < 4) ? c[i] : r[`AFC_DW-1:0];
   endfunction
   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic put(input logic [`AFC_DW-1:0] d, input int lim);
      int n = 0;
      wr_valid_i <= 1'b1;
      wr_data_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wr_ready_o !== 1'b1 && n < lim);
      ok = (wr_ready_o === 1'b1);
      if (ok) exp_q.push_back(d);
   endtask
   task automatic drain;
      for (int n = 0; n < 20000 && exp_q.size() != 0; n++) @(posedge clk_i);
      check("left", 10'(exp_q.size()), 10'd0);
   endtask
   task automatic traffic(input int n);
      for (int i = 0; i < n; i++) begin
         put(word(i), 3000);
         if ($random(seed) % 2) begin
            wr_valid_i <= 1'b0;
            @(posedge clk_i);
         end
      end
      wr_valid_i <= 1'b0;
      drain();
   endtask
   // The reader stalls at random so words wait in the output slot.
   always @(posedge clk_i) rd_ready_i <= !hold && ($random(seed) % 2 != 0);
   always @(posedge clk_i) begin
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
         check("rd_data", {1'b0, rd_data_o}, exp_q.size() ? {1'b0, exp_q.pop_front()} : 10'h3ff);
      end
   end
   initial begin
      reset_i = 1'b1;
      wr_valid_i = 1'b0;
      wr_data_i = '0;
      rewind_req_i = 1'b0;
      hold = 1'b0;
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      traffic(4);
      for (int i = 0; i < 4; i++) exp_q.push_back(word(i));
      rewind_req_i <= 1'b1;
      @(posedge clk_i);
      rewind_req_i <= 1'b0;
      drain();
      $display("test rewind done");
      traffic(60);
      $display("test random done");
      hold <= 1'b1;
      ok = 1'b1;
      for (int i = 4; i < 700 && ok; i++) put(word(i), 300);
      wr_valid_i <= 1'b0;
      check("full_flag", {9'h000, full_n}, 10'h000);
      check("stored", u_dev.cnt, 10'd512);
      hold <= 1'b0;
      drain();
      $display("test fill done");
      hold <= 1'b1;
      for (int i = 4; i < 10; i++) put(word(i), 300);
      wr_valid_i <= 1'b0;
      reset_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      check("reset", {6'h00, rdy, rst_n, empty_n, full_n}, 10'h001);
      exp_q.delete();
      reset_i <= 1'b0;
      hold <= 1'b0;
      traffic(20);
      $display("test reset done");
      final_report();
   end
   initial begin
      repeat (40000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end
endmodule // tb_top
`default_nettype wire
